// *** core/embp_params.svh ***
// constants of the external memory bus port
`ifndef EMBP_PARAMS_SVH
`define EMBP_PARAMS_SVH

`define EMBP_ADDR_W      16
`define EMBP_DATA_W      24
`define EMBP_CLK_NS      10
`define EMBP_ACCESS_NS   40
`define EMBP_ACCESS_CYC  ((`EMBP_ACCESS_NS + `EMBP_CLK_NS - 1) / `EMBP_CLK_NS)
`define EMBP_ADDR_RST    16'h0000
`define EMBP_DATA_RST    24'h00_0000

`endif

// *** core/embp_pkg.sv ***
// types of the external memory bus port
`include "embp_params.svh"
package embp_pkg;
  typedef enum logic [1:0] {
    EMBP_IDLE,
    EMBP_ACCESS,
    EMBP_GRANTED
  } embp_state_t;

  typedef enum logic {
    EMBP_SPACE_PROG,
    EMBP_SPACE_DATA
  } embp_space_t;

  typedef struct packed {
    embp_state_t              st;
    logic [3:0]               cnt;
    logic                     wr;
    logic [`EMBP_ADDR_W-1:0]  addr;
    logic [`EMBP_DATA_W-1:0]  wdata;
    logic [`EMBP_DATA_W-1:0]  rdata;
    logic                     addr_oe_n;
    logic                     data_oe_n;
    logic                     ctl_oe_n;
    logic                     prog_sel_n;
    logic                     data_sel_n;
    logic                     rd_n;
    logic                     wr_n;
    logic                     grant_n;
    logic                     ready;
    logic                     rsp;
  } embp_regs_t;
endpackage

// *** core/embp_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module embp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         srst,
  // pins in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // reset to all ones so an idle active-low request reads as absent
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// *** core/embp_port.sv ***
// external memory bus port: address, data, space strobes and bus grant
`timescale 1ns/1ps
`include "embp_params.svh"
module embp_port (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     srst,
  // core request side
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire logic                     req_write,
  input  wire embp_pkg::embp_space_t    req_space,
  input  wire logic [`EMBP_ADDR_W-1:0]  req_addr,
  input  wire logic [`EMBP_DATA_W-1:0]  req_wdata,
  output logic                          rsp_valid,
  output logic      [`EMBP_DATA_W-1:0]  rsp_rdata,
  // address pins
  output logic      [`EMBP_ADDR_W-1:0]  addr_out,
  output logic                          addr_oe_n,
  // data pins
  input  wire logic [`EMBP_DATA_W-1:0]  data_in,
  output logic      [`EMBP_DATA_W-1:0]  data_out,
  output logic                          data_oe_n,
  // strobe pins, one shared enable
  output logic                          program_space_strobe_n,
  output logic                          data_space_select_n,
  output logic                          read_strobe_n,
  output logic                          write_strobe_n,
  output logic                          ctl_oe_n,
  // arbitration pins
  input  wire logic                     bus_request_n,
  output logic                          bus_grant_out_n
);
  import embp_pkg::*;

  localparam logic [3:0] ACC_LAST = 4'(`EMBP_ACCESS_CYC - 1);

  embp_regs_t                 r;
  embp_regs_t                 n;
  logic                       breq_n_s;
  logic [`EMBP_DATA_W-1:0]    data_s;
  logic                       take;

  // data pins are synchronised too; the access is long enough to cover it
  embp_sync #(.W(`EMBP_DATA_W + 1)) u_sync (
    .clock (clock),
    .srst  (srst),
    .d     ({bus_request_n, data_in}),
    .q     ({breq_n_s, data_s})
  );

  assign take = req_valid && r.ready;

  always_comb begin
    n     = r;
    n.rsp = 1'b0;
    unique case (r.st)
      EMBP_IDLE: begin
        if (take) begin
          // ready was shown, so the request must be served; a bus request waits
          n.st         = EMBP_ACCESS;
          n.cnt        = ACC_LAST;
          n.wr         = req_write;
          n.addr       = req_addr;
          n.wdata      = req_wdata;
          n.prog_sel_n = (req_space != EMBP_SPACE_PROG);
          n.data_sel_n = (req_space != EMBP_SPACE_DATA);
          n.rd_n       = req_write;
          n.wr_n       = !req_write;
          n.data_oe_n  = !req_write;
          n.ready      = 1'b0;
        end else if (!breq_n_s) begin
          // float everything, then grant in the same edge
          n.st        = EMBP_GRANTED;
          n.grant_n   = 1'b0;
          n.addr_oe_n = 1'b1;
          n.data_oe_n = 1'b1;
          n.ctl_oe_n  = 1'b1;
          n.ready     = 1'b0;
        end else begin
          // own the bus: hold last address, deselect both spaces
          n.addr_oe_n  = 1'b0;
          n.ctl_oe_n   = 1'b0;
          n.prog_sel_n = 1'b1;
          n.data_sel_n = 1'b1;
          n.ready      = 1'b1;
        end
      end
      EMBP_ACCESS: begin
        if (r.cnt == 4'h0) begin
          n.st         = EMBP_IDLE;
          n.prog_sel_n = 1'b1;
          n.data_sel_n = 1'b1;
          n.rd_n      = 1'b1;
          n.wr_n      = 1'b1;
          n.data_oe_n = 1'b1;
          n.rsp       = 1'b1;
          if (!r.wr) begin
            n.rdata = data_s;
          end
        end else begin
          n.cnt = r.cnt - 4'h1;
        end
      end
      EMBP_GRANTED: begin
        // pins stay floating; the idle state re-drives them next edge
        if (breq_n_s) begin
          n.st      = EMBP_IDLE;
          n.grant_n = 1'b1;
        end
      end
      default: n.st = EMBP_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r.st        <= EMBP_IDLE;
      r.cnt       <= 4'h0;
      r.wr        <= 1'b0;
      r.addr      <= `EMBP_ADDR_RST;
      r.wdata     <= `EMBP_DATA_RST;
      r.rdata     <= `EMBP_DATA_RST;
      r.addr_oe_n <= 1'b1;
      r.data_oe_n <= 1'b1;
      r.ctl_oe_n  <= 1'b1;
      r.prog_sel_n <= 1'b1;
      r.data_sel_n <= 1'b1;
      r.rd_n      <= 1'b1;
      r.wr_n      <= 1'b1;
      r.grant_n   <= 1'b1;
      r.ready     <= 1'b0;
      r.rsp       <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign req_ready              = r.ready;
  assign rsp_valid              = r.rsp;
  assign rsp_rdata              = r.rdata;
  assign addr_out               = r.addr;
  assign addr_oe_n              = r.addr_oe_n;
  assign data_out               = r.wdata;
  assign data_oe_n              = r.data_oe_n;
  assign program_space_strobe_n = r.prog_sel_n;
  assign data_space_select_n    = r.data_sel_n;
  assign read_strobe_n          = r.rd_n;
  assign write_strobe_n         = r.wr_n;
  assign ctl_oe_n               = r.ctl_oe_n;
  assign bus_grant_out_n        = r.grant_n;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_take_prog;
    take && req_space == EMBP_SPACE_PROG;
  endsequence

  sequence s_take_data;
    take && req_space == EMBP_SPACE_DATA;
  endsequence

  sequence s_take_rd;
    take && !req_write;
  endsequence

  chk_addr_drive: assert property (take |=> !addr_oe_n && addr_out == $past(req_addr))
    else $error("address not driven with request address");
  chk_addr_hold: assert property ((r.st != EMBP_ACCESS && !take) |=> $stable(addr_out))
    else $error("address changed with no access");
  chk_addr_float: assert property (!bus_grant_out_n |-> addr_oe_n)
    else $error("address driven while granted");
  chk_write_data: assert property ((take && req_write) |=> (!data_oe_n && data_out == $past(req_wdata))
                                    ##1 (!data_oe_n && $stable(data_out))[*3])
    else $error("write data not driven during write");
  chk_data_float: assert property (!bus_grant_out_n |-> data_oe_n && ctl_oe_n)
    else $error("data or strobes driven while granted");
  chk_reset_float: assert property ($fell(srst) |-> data_oe_n && addr_oe_n && ctl_oe_n
                                     && bus_grant_out_n)
    else $error("pins not floating after reset");
  chk_prog_strobe: assert property (s_take_prog |=> (!program_space_strobe_n
                                     && data_space_select_n)[*4] ##1 program_space_strobe_n)
    else $error("program strobe length wrong");
  chk_data_strobe: assert property (s_take_data |=> (!data_space_select_n
                                     && program_space_strobe_n)[*4] ##1 data_space_select_n)
    else $error("data strobe length wrong");
  chk_grant_reply: assert property ((r.st == EMBP_IDLE && !breq_n_s && !take)
                                     |=> !bus_grant_out_n)
    else $error("grant not given to request");
  chk_write_strobe: assert property ((take && req_write) |=> (!write_strobe_n
                                      && read_strobe_n)[*4] ##1 write_strobe_n)
    else $error("write strobe length wrong");
  chk_read_strobe: assert property (s_take_rd |=> (!read_strobe_n && write_strobe_n)[*4]
                                     ##1 (read_strobe_n && rsp_valid))
    else $error("read strobe or answer wrong");
  chk_idle_deselect: assert property ((r.st == EMBP_IDLE && !ctl_oe_n) |->
                                       program_space_strobe_n && data_space_select_n)
    else $error("space selected while idle");
endmodule

// *** dv/embp_mem_model.sv ***
// behavioural external program and data memory hanging on the port's pins
`timescale 1ns/1ps
`include "embp_params.svh"
module embp_mem_model (
  // pins from the port
  input  wire logic [`EMBP_ADDR_W-1:0] addr_out,
  input  wire logic                    clock,
  input  wire logic [`EMBP_DATA_W-1:0] data_out,
  input  wire logic                    data_oe_n,
  input  wire logic                    program_space_strobe_n,
  input  wire logic                    data_space_select_n,
  input  wire logic                    read_strobe_n,
  input  wire logic                    write_strobe_n,
  input  wire logic                    ctl_oe_n,
  // data pins back to the port
  output logic      [`EMBP_DATA_W-1:0] data_in
);
  logic [`EMBP_DATA_W-1:0] mem [0:31];
  logic [`EMBP_DATA_W-1:0] last_r = 24'h00_0000;
  logic [4:0]              idx;
  logic                    rd_on;
  logic                    sel;
  assign sel   = !(program_space_strobe_n && data_space_select_n);
  assign idx   = {~data_space_select_n, addr_out[3:0]};
  assign rd_on = !ctl_oe_n && !read_strobe_n && sel;
  // released bus shows the inverse of the last word, so stale data never matches
  assign data_in = rd_on ? mem[idx] : ~last_r;
  always @(posedge clock) begin
    if (rd_on)
      last_r <= mem[idx];
    if (!ctl_oe_n && !data_oe_n && !write_strobe_n && sel)
      mem[idx] <= data_out;
  end
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the external memory bus port
`timescale 1ns/1ps
`include "embp_params.svh"
module testbench;
  import embp_pkg::*;
  logic                    clock = 1'b0;
  logic                    srst = 1'b1;
  logic                    req_valid = 1'b0;
  logic                    req_write = 1'b0;
  logic                    bus_request_n = 1'b1;
  embp_space_t             req_space = EMBP_SPACE_PROG;
  logic [`EMBP_ADDR_W-1:0] req_addr = 16'h0000;
  logic [`EMBP_ADDR_W-1:0] addr_out;
  logic [`EMBP_DATA_W-1:0] req_wdata = 24'h00_0000;
  logic [`EMBP_DATA_W-1:0] data_in, data_out, rsp_rdata;
  logic req_ready, rsp_valid, addr_oe_n, data_oe_n, prog_sel_n, data_sel_n;
  logic rd_n, wr_n, ctl_oe_n, grant_n;
  int n_fail = 0;
  int n_compared = 0;

  initial forever #5 clock = ~clock;

  embp_port i_dut (.clock(clock), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_space(req_space), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .addr_out(addr_out), .addr_oe_n(addr_oe_n),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .program_space_strobe_n(prog_sel_n), .data_space_select_n(data_sel_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .ctl_oe_n(ctl_oe_n), .bus_request_n(bus_request_n),
    .bus_grant_out_n(grant_n));
  embp_mem_model i_mem (.clock(clock), .addr_out(addr_out), .data_out(data_out),
    .data_oe_n(data_oe_n), .program_space_strobe_n(prog_sel_n), .data_space_select_n(data_sel_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .ctl_oe_n(ctl_oe_n), .data_in(data_in));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic reset_test();
    @(posedge clock);
    srst <= 1'b1;
    repeat (5) @(negedge clock);
    chk({addr_oe_n, data_oe_n, ctl_oe_n}, 24'h00_0007);
    chk({grant_n, req_ready}, 24'h00_0002);
    chk(addr_out, 24'h00_0000);
    @(posedge clock);
    srst <= 1'b0;
    $display("test reset done");
  endtask

  task automatic access(input logic w, input embp_space_t sp, input logic [15:0] a,
                        input logic [23:0] d, input logic [23:0] exp_rd);
    int k;
    k = 0;
    @(negedge clock);
    while (req_ready !== 1'b1 && k < 20) begin
      @(negedge clock);
      k++;
    end
    if (k == 20)
      n_fail++;
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= w;
    req_space <= sp;
    req_addr  <= a;
    req_wdata <= d;
    // ready is a level, so the request is taken at this edge
    @(posedge clock);
    req_valid <= 1'b0;
    @(negedge clock);
    chk(addr_out, a);
    chk({prog_sel_n, data_sel_n}, {sp == EMBP_SPACE_DATA, sp == EMBP_SPACE_PROG});
    chk({rd_n, wr_n, data_oe_n, req_ready}, {w, !w, !w, 1'b0});
    if (w)
      chk(data_out, d);
    repeat (4) @(negedge clock);
    chk({rsp_valid, prog_sel_n, data_sel_n, rd_n, wr_n}, 24'h00_001f);
    if (!w)
      chk(rsp_rdata, exp_rd);
    @(negedge clock);
    chk({rsp_valid, prog_sel_n, data_sel_n, addr_oe_n}, 24'h00_0006);
    chk(addr_out, a);
  endtask

  // bus request seen in the same edge as a core request: the access runs first
  task automatic race_test();
    @(posedge clock);
    bus_request_n <= 1'b0;
    @(posedge clock);
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= 1'b0;
    req_space <= EMBP_SPACE_DATA;
    req_addr  <= 16'h0005;
    @(posedge clock);
    req_valid <= 1'b0;
    @(negedge clock);
    chk({data_sel_n, rd_n, grant_n}, 24'h00_0001);
    repeat (4) @(negedge clock);
    chk(rsp_valid, 24'h00_0001);
    chk(rsp_rdata, 24'h65_4321);
    @(negedge clock);
    chk({grant_n, addr_oe_n}, 24'h00_0001);
    @(posedge clock);
    bus_request_n <= 1'b1;
    repeat (5) @(negedge clock);
    chk({grant_n, req_ready}, 24'h00_0003);
    $display("test race done");
  endtask

  task automatic grant_test(input logic [15:0] a);
    @(posedge clock);
    bus_request_n <= 1'b0;
    repeat (4) @(negedge clock);
    chk({grant_n, req_ready}, 24'h00_0000);
    chk({addr_oe_n, data_oe_n, ctl_oe_n}, 24'h00_0007);
    @(posedge clock);
    bus_request_n <= 1'b1;
    repeat (4) @(negedge clock);
    chk({grant_n, addr_oe_n}, 24'h00_0003);
    @(negedge clock);
    chk({addr_oe_n, ctl_oe_n, prog_sel_n, data_sel_n, req_ready}, 24'h00_0007);
    chk(addr_out, a);
    $display("test grant done");
  endtask

  initial begin
    reset_test();
    access(1'b1, EMBP_SPACE_PROG, 16'h0005, 24'h12_3456, 24'h00_0000);
    access(1'b1, EMBP_SPACE_DATA, 16'h0005, 24'h65_4321, 24'h00_0000);
    access(1'b0, EMBP_SPACE_PROG, 16'h0005, 24'h00_0000, 24'h12_3456);
    access(1'b0, EMBP_SPACE_DATA, 16'h0005, 24'h00_0000, 24'h65_4321);
    race_test();
    access(1'b1, EMBP_SPACE_DATA, 16'hffff, 24'hff_ffff, 24'h00_0000);
    access(1'b0, EMBP_SPACE_DATA, 16'hffff, 24'h00_0000, 24'hff_ffff);
    $display("test access done");
    grant_test(16'hffff);
    access(1'b0, EMBP_SPACE_PROG, 16'h0005, 24'h00_0000, 24'h12_3456);
    reset_test();
    access(1'b0, EMBP_SPACE_DATA, 16'h0005, 24'h00_0000, 24'h65_4321);
    $display("test after reset done");
    wrap_up();
  end

  // whole run needs about a hundred cycles; allow twenty times that
  initial begin
    #20000;
    n_fail++;
    wrap_up();
  end
endmodule
